// ### verilog/rissl_top.sv
// Reference input select and status slew configuration with an APB slave.
//
// Contract
// - Bits 3:2 of the slew register set the second status edge rate, reset 0, 0 fast, 2 slow.
// - Bits 1:0 of the slew register set the first status edge rate, reset 0, 0 fast, 2 slow.
// - Bits 7:6 of the select register set the secondary buffer mode, reset 2, 3 disables.
// - Bits 5:4 of the select register set the primary buffer mode, reset 1, 2 or 3 disable.
// - Bits 1:0 of the select register pick auto, pin, forced primary or forced secondary.
// - In pin mode the three-level pin selects primary low, secondary mid, automatic high.
// - Bits 3:2 of the select register are plain read-write storage resetting to 1.
// - The chosen reference goes through the glitch-free mux unless the bypass bit is set.
`timescale 1ns/10ps
`default_nettype none
`include "rissl_map.svh"
module rissl_top
    import rissl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ref_choice_pin,
    input wire logic pri_clock_valid,
    input wire logic sec_clock_valid,
    output logic [1:0] first_status_edge_rate,
    output logic [1:0] second_status_edge_rate,
    output logic [1:0] primary_buffer_mode,
    output logic [1:0] secondary_buffer_mode,
    output logic primary_buffer_enable,
    output logic secondary_buffer_enable,
    output logic use_secondary_ref,
    output logic glitchfree_mux_bypass
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] status_output_slew_control;
    logic [7:0] reference_input_select;
    logic [7:0] input_clock_control;
    logic [1:0] pin_s1, pin_s2;
    logic pri_s1, pri_s2, sec_s1, sec_s2;
    logic wr_en;
    logic [9:0] word_idx;
    logic hit;
    logic [7:0] next_rdata;

    rissl_sel_if sel_bus();

    assign word_idx = paddr[11:2];
    assign wr_en = psel && penable && pwrite && pstrb[0];

    // The status word reports the synchronised valid levels and the current choice.
    always_comb begin
        hit = 1'b1;
        next_rdata = 8'h00;
        case (word_idx)
            {2'h0, `RISSL_IDX_SLEW}: next_rdata = {4'h0, status_output_slew_control[3:0]};
            {2'h0, `RISSL_IDX_INSEL}: next_rdata = reference_input_select;
            {2'h0, `RISSL_IDX_CTRL}: next_rdata = input_clock_control;
            {2'h0, `RISSL_IDX_STAT}: next_rdata = {5'h00, sec_s2, pri_s2, use_secondary_ref};
            default: hit = 1'b0;
        endcase
    end

    // Slew bits above the two fields are not implemented and read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_output_slew_control <= `RISSL_SLEW_RESET;
        end else if (wr_en && word_idx == {2'h0, `RISSL_IDX_SLEW}) begin
            status_output_slew_control <= {4'h0, pwdata[3:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_input_select <= `RISSL_INSEL_RESET;
        end else if (wr_en && word_idx == {2'h0, `RISSL_IDX_INSEL}) begin
            reference_input_select <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_clock_control <= `RISSL_CTRL_RESET;
        end else if (wr_en && word_idx == {2'h0, `RISSL_IDX_CTRL}) begin
            input_clock_control <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Read data is captured in the setup cycle so that it stands through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, next_rdata};
        end
    end

    // Every register answers at once, so the access phase always ends after one cycle.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Each bit of the pin code is synchronised on its own; a change between codes may show
    // a neighbouring code for one cycle, which the chooser simply follows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pri_s1 <= 1'b0;
            pri_s2 <= 1'b0;
            sec_s1 <= 1'b0;
            sec_s2 <= 1'b0;
        end else begin
            pin_s1 <= ref_choice_pin;
            pin_s2 <= pin_s1;
            pri_s1 <= pri_clock_valid;
            pri_s2 <= pri_s1;
            sec_s1 <= sec_clock_valid;
            sec_s2 <= sec_s1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sel_bus.mode = reference_input_select[`RISSL_SEL_MSB:`RISSL_SEL_LSB];
    assign sel_bus.pin_level = pin_s2;
    assign sel_bus.pri_valid = pri_s2;
    assign sel_bus.sec_valid = sec_s2;

    rissl_chooser u_chooser (
        .pclk(pclk),
        .presetn(presetn),
        .sel(sel_bus)
    );

    assign use_secondary_ref = sel_bus.use_secondary;
    assign glitchfree_mux_bypass = input_clock_control[`RISSL_BYPASS_BIT];
    assign second_status_edge_rate =
        status_output_slew_control[`RISSL_SLEW2_MSB:`RISSL_SLEW2_LSB];
    assign first_status_edge_rate =
        status_output_slew_control[`RISSL_SLEW1_MSB:`RISSL_SLEW1_LSB];
    assign secondary_buffer_mode = reference_input_select[`RISSL_SEC_MSB:`RISSL_SEC_LSB];
    assign primary_buffer_mode = reference_input_select[`RISSL_PRI_MSB:`RISSL_PRI_LSB];
    assign secondary_buffer_enable = secondary_buffer_mode != 2'h3;
    assign primary_buffer_enable = !primary_buffer_mode[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    slew_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && word_idx == {2'h0, `RISSL_IDX_SLEW})
        |=> second_status_edge_rate == $past(pwdata[3:2]))
        else $error("second edge rate not updated");
    slew_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && word_idx == {2'h0, `RISSL_IDX_SLEW})
        |=> first_status_edge_rate == $past(pwdata[1:0]))
        else $error("first edge rate not updated");
    sec_buf_a: assert property (@(posedge pclk) disable iff (!presetn)
        secondary_buffer_enable == (secondary_buffer_mode != 2'h3))
        else $error("secondary buffer enable wrong");
    pri_buf_a: assert property (@(posedge pclk) disable iff (!presetn)
        primary_buffer_mode >= 2'h2 |-> !primary_buffer_enable)
        else $error("primary buffer not disabled");
    rsv_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && word_idx == {2'h0, `RISSL_IDX_INSEL})
        |=> $stable(reference_input_select[3:2]))
        else $error("reserved bits changed without a write");
    bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && word_idx == {2'h0, `RISSL_IDX_CTRL})
        |=> glitchfree_mux_bypass == $past(pwdata[7]))
        else $error("bypass bit not taken");
    pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_bus.mode == RISSL_SEL_PIN && pin_s2 == RISSL_PIN_LOW) |=> !use_secondary_ref)
        else $error("low pin level did not pick primary");
    auto_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_bus.mode == RISSL_SEL_AUTO && !pri_s2 && sec_s2) |=> use_secondary_ref)
        else $error("automatic mode did not fall back");
    forced_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel_bus.mode == RISSL_SEL_PRI |=> !use_secondary_ref)
        else $error("forced primary not chosen");
    pin_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_bus.mode == RISSL_SEL_PIN && pin_s2 == RISSL_PIN_HIGH && pri_s2)
        |=> !use_secondary_ref)
        else $error("high pin level left a valid primary");
    pin_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_bus.mode == RISSL_SEL_PIN && pin_s2 == RISSL_PIN_HIGH && !pri_s2 && sec_s2)
        |=> use_secondary_ref)
        else $error("high pin level did not fall back");
    insel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && word_idx == {2'h0, `RISSL_IDX_INSEL})
        |=> reference_input_select == $past(pwdata[7:0]))
        else $error("select register not updated");
    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && word_idx == {2'h0, `RISSL_IDX_CTRL})
        |=> input_clock_control == $past(pwdata[7:0]))
        else $error("control register not updated");
    slew_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_output_slew_control[7:4] == 4'h0)
        else $error("unused slew bits set");
    rdata_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite) |=> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    rd_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !hit) |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### include/rissl_map.svh
// Register offsets, field positions and reset values of the reference select block.
`ifndef RISSL_MAP_SVH
`define RISSL_MAP_SVH

// Printed offsets are word indices, not byte addresses (0x34 only looks like one): byte address is four times.
`define RISSL_IDX_SLEW 8'h31
`define RISSL_IDX_INSEL 8'h32
`define RISSL_IDX_CTRL 8'h33
`define RISSL_IDX_STAT 8'h34

`define RISSL_SLEW_RESET 8'h00
`define RISSL_INSEL_RESET 8'h95
`define RISSL_CTRL_RESET 8'h00

`define RISSL_SLEW2_MSB 3
`define RISSL_SLEW2_LSB 2
`define RISSL_SLEW1_MSB 1
`define RISSL_SLEW1_LSB 0
`define RISSL_SEC_MSB 7
`define RISSL_SEC_LSB 6
`define RISSL_PRI_MSB 5
`define RISSL_PRI_LSB 4
`define RISSL_RSV_MSB 3
`define RISSL_RSV_LSB 2
`define RISSL_SEL_MSB 1
`define RISSL_SEL_LSB 0
`define RISSL_BYPASS_BIT 7

`define RISSL_SLEW_FAST 2'h0
`define RISSL_SLEW_SLOW 2'h2

`endif

// ### include/rissl_pkg.sv
// Types of the reference select block.
package rissl_pkg;
    typedef enum logic [1:0] {
        RISSL_SEL_AUTO = 2'b00,
        RISSL_SEL_PIN = 2'b01,
        RISSL_SEL_PRI = 2'b10,
        RISSL_SEL_SEC = 2'b11
    } rissl_sel_t;

    typedef enum logic [1:0] {
        RISSL_PIN_LOW = 2'b00,
        RISSL_PIN_MID = 2'b01,
        RISSL_PIN_HIGH = 2'b10
    } rissl_pin_t;
endpackage

// ### include/rissl_sel_if.sv
// Signals between the register file and the source chooser.
`timescale 1ns/10ps
`default_nettype none
interface rissl_sel_if;
    import rissl_pkg::*;
    logic [1:0] mode;
    logic [1:0] pin_level;
    logic pri_valid;
    logic sec_valid;
    logic use_secondary;
    modport ctrl (output mode, output pin_level, output pri_valid, output sec_valid,
                  input use_secondary);
    modport chooser (input mode, input pin_level, input pri_valid, input sec_valid,
                     output use_secondary);
endinterface
`default_nettype wire

// ### verilog/rissl_chooser.sv
// Source chooser: decodes the selection mode and picks primary or secondary.
`timescale 1ns/10ps
`default_nettype none
module rissl_chooser
    import rissl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    rissl_sel_if.chooser sel
);
    logic next_use_secondary;
    logic use_secondary;

    // Pin mode resolves to a fixed choice or to automatic.
    always_comb begin
        next_use_secondary = 1'b0;
        case (sel.mode)
            RISSL_SEL_AUTO: next_use_secondary = !sel.pri_valid && sel.sec_valid;
            RISSL_SEL_PIN: begin
                case (sel.pin_level)
                    RISSL_PIN_LOW: next_use_secondary = 1'b0;
                    RISSL_PIN_MID: next_use_secondary = 1'b1;
                    RISSL_PIN_HIGH: next_use_secondary = !sel.pri_valid && sel.sec_valid;
                    default: next_use_secondary = 1'b0;
                endcase
            end
            RISSL_SEL_PRI: next_use_secondary = 1'b0;
            RISSL_SEL_SEC: next_use_secondary = 1'b1;
            default: next_use_secondary = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_secondary <= 1'b0;
        end else begin
            use_secondary <= next_use_secondary;
        end
    end

    assign sel.use_secondary = use_secondary;

    forced_sec_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel.mode == RISSL_SEL_SEC |=> use_secondary)
        else $error("forced secondary not chosen");
    auto_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel.mode == RISSL_SEL_AUTO && sel.pri_valid) |=> !use_secondary)
        else $error("automatic mode left a valid primary");
    pin_mid_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sel.mode == RISSL_SEL_PIN && sel.pin_level == RISSL_PIN_MID) |=> use_secondary)
        else $error("mid pin level did not pick secondary");
endmodule
`default_nettype wire

// ### sim/rissl_ref_sources.sv
// Model of the reference clock sources and the board-driven select pin.
`timescale 1ns/10ps
`default_nettype none
module rissl_ref_sources
    import rissl_pkg::*;
(
    input wire logic pclk,
    input wire logic want_pri_ok,
    input wire logic want_sec_ok,
    input wire rissl_pin_t want_level,
    output logic pri_clock_valid,
    output logic sec_clock_valid,
    output logic [1:0] ref_choice_pin
);
    // Sources report clock presence; the board only ever drives one of the three levels.
    always @(posedge pclk) begin
        pri_clock_valid <= want_pri_ok;
        sec_clock_valid <= want_sec_ok;
        ref_choice_pin <= want_level;
    end
endmodule
`default_nettype wire

// ### sim/tb_ref_input_select_and_status_slew.sv
// Self-checking bench for the reference select and status slew block.
`timescale 1ns/10ps
`default_nettype none
`include "rissl_map.svh"
module tb_ref_input_select_and_status_slew
    import rissl_pkg::*;
;
    typedef struct {
        logic [7:0] sel;
        rissl_pin_t lvl;
        logic pv;
        logic sv;
        logic sec;
    } rissl_row_t;
    rissl_row_t rows [10] = '{'{8'h95, RISSL_PIN_LOW, 1, 1, 0}, '{8'h95, RISSL_PIN_MID, 1, 1, 1},
        '{8'h95, RISSL_PIN_HIGH, 0, 1, 1}, '{8'h95, RISSL_PIN_HIGH, 1, 1, 0},
        '{8'h00, RISSL_PIN_MID, 1, 1, 0}, '{8'h00, RISSL_PIN_MID, 0, 1, 1},
        '{8'h00, RISSL_PIN_MID, 1, 0, 0}, '{8'hE2, RISSL_PIN_MID, 0, 1, 0},
        '{8'h7B, RISSL_PIN_LOW, 1, 0, 1}, '{8'h5F, RISSL_PIN_LOW, 1, 1, 1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] pin, fse, sse, pbm, sbm, en_exp;
    logic pcv, scv, pbe, sbe, usr, gmb, want_pri_ok, want_sec_ok;
    rissl_pin_t want_level;
    int mismatches = 0;
    int compares = 0;

    rissl_top rissl_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_choice_pin(pin), .pri_clock_valid(pcv),
        .sec_clock_valid(scv), .first_status_edge_rate(fse), .second_status_edge_rate(sse),
        .primary_buffer_mode(pbm), .secondary_buffer_mode(sbm), .primary_buffer_enable(pbe),
        .secondary_buffer_enable(sbe), .use_secondary_ref(usr), .glitchfree_mux_bypass(gmb));
    rissl_ref_sources rissl_ref_sources_inst (.pclk(pclk), .want_pri_ok(want_pri_ok),
        .want_sec_ok(want_sec_ok), .want_level(want_level), .pri_clock_valid(pcv),
        .sec_clock_valid(scv), .ref_choice_pin(pin));

    // ------------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task apb(input logic dir, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= dir;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 4'hF);
        @(posedge pclk);
    endtask
    task rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 4'hF);
        check(rd, exp);
    endtask
    task finish_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
        want_pri_ok <= 1'b1;
        want_sec_ok <= 1'b1;
        want_level <= RISSL_PIN_LOW;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`RISSL_IDX_SLEW, 32'h0);
        rdchk(`RISSL_IDX_INSEL, 32'h95);
        check({27'h0, gmb, sbm, pbm}, {27'h0, 1'b0, 2'h2, 2'h1});
        for (int i = 0; i < 10; i++) begin
            want_pri_ok <= rows[i].pv;
            want_sec_ok <= rows[i].sv;
            want_level <= rows[i].lvl;
            wr(`RISSL_IDX_INSEL, {24'h0, rows[i].sel});
            repeat (5) @(posedge pclk);
            check({31'h0, usr}, {31'h0, rows[i].sec});
            check({28'h0, sbm, pbm}, {28'h0, rows[i].sel[7:4]});
            en_exp = {!rows[i].sel[5], rows[i].sel[7:6] != 2'h3};
            check({30'h0, pbe, sbe}, {30'h0, en_exp});
            rdchk(`RISSL_IDX_INSEL, {24'h0, rows[i].sel});
        end
        for (int v = 0; v < 16; v++) begin
            wr(`RISSL_IDX_SLEW, {24'h0, 4'hF, v[3:0]});
            check({28'h0, sse, fse}, {28'h0, v[3:0]});
            rdchk(`RISSL_IDX_SLEW, {28'h0, v[3:0]});
        end
        apb(1'b1, `RISSL_IDX_INSEL, 32'h0, 4'h0);
        rdchk(`RISSL_IDX_INSEL, 32'h5F);
        apb(1'b0, 8'h35, 32'h0, 4'hF);
        check({rd[30:0], err}, 32'h1);
        wr(`RISSL_IDX_CTRL, 32'h80);
        check({31'h0, gmb}, 32'h1);
        rdchk(`RISSL_IDX_CTRL, 32'h80);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check({31'h0, gmb}, 32'h0);
        rdchk(`RISSL_IDX_INSEL, 32'h95);
        rdchk(`RISSL_IDX_SLEW, 32'h0);
        rdchk(`RISSL_IDX_STAT, 32'h6);
        finish_test;
    end
endmodule
`default_nettype wire
